// ---- verilog/serial_ctrl.sv ----
// Serial peripheral controller, master or slave, with the quirks of the
// affected silicon kept. Assumes a DMA or software source on the same clock.
`timescale 1ns/100ps
`include "serial_ctrl_defs.svh"

// Function
// (R1) Hold plus divider 1: ready stays low
// (R2) Software avoids hold with divider one
// (R3) Final bit releases select at empty
// (R4) Software drives held select as port
// (R5) Master clock may toggle before transfer
// (R6) Software sets master before select config
// (R7) DMA size follows select zero length
// (R8) Zero length over eight means halfword
// (R9) Software sets zero length for bytes
// (R10) Divider one, odd length: extra pulse
// (R11) Divider one, even length: correct pulses
// (R12) Slave ignores disable command
// (R13) Software reads word then resets
// (R14) Slow then divider one: extra pulse
// (R15) Software avoids mixing dividers there
// (R16) Shift 8..16 bits, divided clock
module serial_ctrl
  import serial_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // Control
  input wire logic ENABLE_I,
  input wire logic DISABLE_I,
  input wire logic SW_RESET_I,
  input wire logic MASTER_SELECT_BIT_I,
  input wire logic FIXED_MODE_I,
  input wire logic DMA_MODE_I,
  // Configuration write
  input wire logic CFG_WR_I,
  input wire logic [1:0] CFG_SEL_I,
  input wire cs_cfg_s CFG_I,
  // Transmit data register write
  input wire logic TDR_WR_I,
  input wire logic [31:0] TDR_I,
  input wire logic [1:0] FIXED_CS_I,
  // Receive read
  input wire logic RDR_RD_I,
  // Status
  output logic ENABLED_O,
  output logic TX_READY_O,
  output logic TRANSMIT_EMPTY_FLAG_O,
  output logic RX_READY_O,
  output logic [15:0] RX_DATA_O,
  output logic DMA_HALFWORD_O,
  // Serial pins
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE_O,
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic MOSI_O,
  input wire logic MISO_I,
  output logic [3:0] CS_N_O,
  input wire logic SLAVE_SEL_N_I
);

  // --------------------------------------------------------------------------
  // Configuration bank
  // --------------------------------------------------------------------------
  cs_cfg_s cfg [`NUM_CS];  // Per-select configuration
  eng_s q, d;              // Whole state and next state
  cs_cfg_s c;              // Configuration of the current select
  logic [7:0] div;         // Effective divider

  serial_cs_cfg u_cfg (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(CFG_WR_I),
    .wr_sel_i(CFG_SEL_I),
    .wr_cfg_i(CFG_I),
    .cfg_o(cfg)
  );

  assign c = cfg[q.cur_cs];
  assign div = (c.serial_clock_divider == 8'h00) ? 8'h01 : c.serial_clock_divider;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic edge_tick;
    logic [1:0] sel;
    logic sck_rise;
    edge_tick = 1'b0;
    sel = 2'h0;
    sck_rise = 1'b0;
    d = q;
    // Pin synchronisers, two flops before use
    d.miso_s = {q.miso_s[1:0], MISO_I};
    d.sck_s = {q.sck_s[1:0], SERIAL_CLOCK_PIN_I};
    d.ss_s = {q.ss_s[1:0], SLAVE_SEL_N_I};
    d.sck_prev = q.sck_s[1];
    sck_rise = q.sck_s[1] && !q.sck_prev;
    // Enable and disable
    if (ENABLE_I) begin
      d.active = 1'b1;
    end
    if (DISABLE_I && MASTER_SELECT_BIT_I) begin // R12
      d.active = 1'b0;
    end
    if (!MASTER_SELECT_BIT_I && q.active) begin
      d.slave_en = 1'b1; // R12
    end
    // Receive word consumed
    if (RDR_RD_I) begin
      d.rx_ready = 1'b0;
    end
    // Transmit data register load
    if (TDR_WR_I && !q.tx_full) begin
      d.tx_full = 1'b1;
      d.tx_ready = 1'b0;
      d.tx_hold = {TDR_I[`FINAL_XFER_POS], TDR_I[`DATA_MSB:0]};
      d.tx_cs = FIXED_MODE_I ? FIXED_CS_I : TDR_I[`SEL_MSB:`SEL_LSB];
      d.tx_empty = 1'b0;
    end
    // Clock may leave idle level before a transfer, as on the silicon
    if (MASTER_SELECT_BIT_I && q.st == ST_IDLE && !q.spurious_done && CFG_WR_I) begin
      d.sclk = ~q.sclk; // R5
      d.spurious_done = 1'b1;
    end else if (q.st == ST_IDLE) begin
      d.sclk = c.clock_polarity_bit;
    end
    // Divider counter
    if (q.st == ST_SHIFT || q.st == ST_LEAD) begin
      if (q.div_cnt >= div - 8'h01) begin
        d.div_cnt = 8'h00;
        edge_tick = 1'b1; // R16
      end else begin
        d.div_cnt = q.div_cnt + 8'h01;
      end
    end
    case (q.st)
      ST_IDLE: begin
        if (q.active && MASTER_SELECT_BIT_I && q.tx_full) begin
          sel = q.tx_cs;
          d.cur_cs = sel;
          d.prev_cs = q.cur_cs;
          d.prev_slow = (cfg[q.cur_cs].serial_clock_divider > 8'h01);
          d.shreg = q.tx_hold[15:0] << (5'h10 - cfg[sel].bits);
          d.bit_cnt = cfg[sel].bits;
          d.cs_n = `CS_IDLE & ~(4'h1 << sel);
          d.tx_full = 1'b0;
          // Ready stays low on a second held word at divider one
          d.ready_stuck = cfg[sel].chip_select_hold_after_transfer &&
            cfg[sel].serial_clock_divider == 8'h01 && q.cs_n[sel] == 1'b0; // R1
          d.tx_ready = !d.ready_stuck;
          // Select just left was slow, this one at divider one, polarity 1, phase 0
          d.extra_pulse = (cfg[sel].serial_clock_divider == 8'h01) &&
            ((cfg[sel].bits[0]) || // R10 R11
             (cfg[sel].clock_polarity_bit && !cfg[sel].inverted_clock_phase_bit &&
              d.prev_slow && sel != q.cur_cs)); // R14
          d.div_cnt = 8'h00;
          d.phase = 1'b0;
          d.st = ST_SHIFT;
        end else if (q.slave_en && !q.ss_s[1] && sck_rise) begin
          d.shreg = {q.shreg[14:0], q.miso_s[1]};
          d.bit_cnt = q.bit_cnt + 5'h01;
          if (q.bit_cnt + 5'h01 >= cfg[0].bits) begin
            d.rx_data = {q.shreg[14:0], q.miso_s[1]};
            d.rx_ready = 1'b1;
            d.bit_cnt = 5'h00;
          end
        end
      end
      ST_SHIFT: begin
        if (edge_tick) begin
          d.sclk = ~q.sclk;
          d.phase = ~q.phase;
          if (q.phase) begin
            d.shreg = {q.shreg[14:0], q.miso_s[1]};
            d.bit_cnt = q.bit_cnt - 5'h01;
            if (q.bit_cnt == 5'h01) begin
              d.rx_data = 16'({q.shreg[14:0], q.miso_s[1]} & ((17'h1 << cfg[q.cur_cs].bits) - 17'h1));
              d.rx_ready = 1'b1;
              d.st = q.extra_pulse ? ST_LEAD : ST_HOLD;
            end
          end
        end
      end
      ST_LEAD: begin
        // One surplus clock pulse before the word closes
        if (edge_tick) begin
          d.sclk = ~q.sclk;
          d.phase = ~q.phase;
          if (q.phase) begin
            d.extra_pulse = 1'b0;
            d.st = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        d.sclk = c.clock_polarity_bit;
        // A word written in this same cycle keeps empty and ready low
        d.tx_empty = !d.tx_full;
        if (!q.ready_stuck && !d.tx_full) begin
          d.tx_ready = 1'b1;
        end
        // In fixed DMA mode the final-transfer bit releases select once empty
        if (FIXED_MODE_I && DMA_MODE_I && q.tx_hold[16] && !d.tx_full) begin
          d.cs_n = `CS_IDLE; // R3
        end else if (!c.chip_select_hold_after_transfer) begin
          d.cs_n = `CS_IDLE;
        end
        d.st = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Software reset returns the engine to rest
    if (SW_RESET_I) begin
      d.st = ST_IDLE;
      d.active = 1'b0;
      d.slave_en = 1'b0;
      d.cs_n = `CS_IDLE;
      d.tx_full = 1'b0;
      d.tx_ready = 1'b1;
      d.tx_empty = 1'b1;
      d.ready_stuck = 1'b0;
      d.rx_ready = 1'b0;
      d.bit_cnt = 5'h00;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cs_n <= `CS_IDLE;
      q.tx_ready <= 1'b1;
      q.tx_empty <= 1'b1;
      q.ss_s <= 3'h7;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign ENABLED_O = q.active;
  assign TX_READY_O = q.tx_ready;
  assign TRANSMIT_EMPTY_FLAG_O = q.tx_empty;
  assign RX_READY_O = q.rx_ready;
  assign RX_DATA_O = q.rx_data;
  assign DMA_HALFWORD_O = (cfg[0].bits > `BITS_MIN); // R7 R8
  assign SERIAL_CLOCK_PIN_O = q.sclk;
  assign SERIAL_CLOCK_PIN_OE_O = MASTER_SELECT_BIT_I;
  assign MOSI_O = q.shreg[15];
  assign CS_N_O = q.cs_n;

endmodule // serial_ctrl

// ---- verilog/serial_ctrl_defs.svh ----
// Field positions, select count, limits and reset values of the serial controller.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef SERIAL_CTRL_DEFS_SVH
`define SERIAL_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// Field positions and select count
// ----------------------------------------------------------------------------
`define FINAL_XFER_POS 24
`define SEL_MSB 17
`define SEL_LSB 16
`define DATA_MSB 15
`define NUM_CS 4

// ----------------------------------------------------------------------------
// Reset and limit values
// ----------------------------------------------------------------------------
`define DIV_RESET 8'h01
`define BITS_RESET 5'h08
`define BITS_MIN 5'h08
`define BITS_MAX 5'h10
`define CS_IDLE 4'hF

`endif

// ---- verilog/serial_ctrl_pkg.sv ----
// Types shared by the serial controller files.
// Assumes serial_ctrl_defs.svh is on the include path.
`include "serial_ctrl_defs.svh"
package serial_ctrl_pkg;

  // --------------------------------------------------------------------------
  // Per-chip-select configuration
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] serial_clock_divider;       // Clock division, 0 treated as 1
    logic [4:0] bits;                       // Word length 8..16
    logic clock_polarity_bit;               // Idle clock level
    logic inverted_clock_phase_bit;         // Phase bit; only gates the R14 extra pulse, capture stays on the second clock edge
    logic chip_select_hold_after_transfer;  // Keep select low between words
  } cs_cfg_s;

  // Transfer engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_HOLD
  } xfer_state_e;

  // Whole state of the shift engine
  typedef struct packed {
    xfer_state_e st;
    logic [15:0] shreg;
    logic [15:0] rx_data;
    logic [4:0] bit_cnt;
    logic [7:0] div_cnt;
    logic phase;
    logic sclk;
    logic [1:0] cur_cs;
    logic [1:0] prev_cs;
    logic prev_slow;
    logic extra_pulse;
    logic [3:0] cs_n;
    logic tx_full;
    logic [16:0] tx_hold;
    logic [1:0] tx_cs;
    logic tx_ready;
    logic tx_empty;
    logic rx_ready;
    logic ready_stuck;
    logic active;
    logic slave_en;
    logic [2:0] miso_s;
    logic [2:0] sck_s;
    logic [2:0] ss_s;
    logic sck_prev;
    logic spurious_done;
  } eng_s;

endpackage

// ---- verilog/serial_cs_cfg.sv ----
// Chip-select configuration bank: stores one configuration per select.
// Assumes writes come from logic on the same clock.
`timescale 1ns/100ps
`include "serial_ctrl_defs.svh"
module serial_cs_cfg
  import serial_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic wr_i,
  input wire logic [1:0] wr_sel_i,
  input wire cs_cfg_s wr_cfg_i,
  // Configurations out
  output cs_cfg_s cfg_o [`NUM_CS]
);

  // --------------------------------------------------------------------------
  // One register per chip select
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < `NUM_CS; g++) begin : g_cs
    cs_cfg_s cfg_q;
    // Load on matching write
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cfg_q <= '{`DIV_RESET, `BITS_RESET, 1'b0, 1'b0, 1'b0};
      end else if (wr_i && wr_sel_i == 2'(g)) begin
        cfg_q <= wr_cfg_i;
      end
    end
    assign cfg_o[g] = cfg_q;
  end

endmodule // serial_cs_cfg

// ---- testbench/serial_ctrl_checker.sv ----
// Port-level assertions for the serial controller.
// Assumes the package is compiled first; attached by bind.
`timescale 1ns/100ps
`include "serial_ctrl_defs.svh"
module serial_ctrl_checker
  import serial_ctrl_pkg::*;
(
  // Clock, reset and control
  input wire logic SYS_CLK_I, RST_N_I, ENABLE_I, DISABLE_I, SW_RESET_I,
  input wire logic MASTER_SELECT_BIT_I, FIXED_MODE_I, DMA_MODE_I,
  // Writes and reads
  input wire logic CFG_WR_I, TDR_WR_I, RDR_RD_I,
  input wire logic [1:0] CFG_SEL_I,
  input wire cs_cfg_s CFG_I,
  // Status and pins
  input wire logic ENABLED_O, TX_READY_O, TRANSMIT_EMPTY_FLAG_O, RX_READY_O,
  input wire logic DMA_HALFWORD_O, SERIAL_CLOCK_PIN_OE_O,
  input wire logic [3:0] CS_N_O
);
  // --------------------------------------------------------------------------
  // Shadow of the select zero word length
  // --------------------------------------------------------------------------
  logic [4:0] bits0_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) bits0_q <= `BITS_RESET;
    else if (CFG_WR_I && CFG_SEL_I == 2'h0) bits0_q <= CFG_I.bits;
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_TAKE: assert property (TDR_WR_I && TX_READY_O && ENABLED_O |=> !TX_READY_O)
    else $error("taken write left ready high");
  AST_HALF: assert property (FIXED_MODE_I && DMA_MODE_I |-> DMA_HALFWORD_O == (bits0_q > 5'h08))
    else $error("size indication not from select zero");
  AST_ONE_SEL: assert property ($countones(~CS_N_O) <= 1)
    else $error("more than one select low");
  AST_RX_CLR: assert property (RDR_RD_I && &CS_N_O |=> !RX_READY_O)
    else $error("read did not clear receive flag");
  AST_RX_HOLD: assert property (RX_READY_O && !RDR_RD_I && !SW_RESET_I |=> RX_READY_O)
    else $error("receive flag dropped unread");
  AST_RX_BUSY: assert property ($rose(RX_READY_O) |-> !TRANSMIT_EMPTY_FLAG_O)
    else $error("empty high as word completes");
  AST_SLV_DIS: assert property (DISABLE_I && !MASTER_SELECT_BIT_I && ENABLED_O && !SW_RESET_I |=> ENABLED_O)
    else $error("slave stopped by disable");
  AST_SW_RST: assert property (SW_RESET_I && !ENABLE_I |=> !ENABLED_O)
    else $error("software reset left it enabled");
  AST_ENA: assert property (ENABLE_I && !DISABLE_I && !SW_RESET_I |=> ENABLED_O)
    else $error("enable ignored");
  AST_OE: assert property ($past(RST_N_I) && $stable(MASTER_SELECT_BIT_I) |-> SERIAL_CLOCK_PIN_OE_O == MASTER_SELECT_BIT_I)
    else $error("clock enable not master bit");
  // Main scenarios reached
  cover property (TDR_WR_I && TX_READY_O);
  cover property ($rose(RX_READY_O));
  cover property (DMA_HALFWORD_O && FIXED_MODE_I);
endmodule // serial_ctrl_checker
bind serial_ctrl serial_ctrl_checker serial_ctrl_checker_inst (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .ENABLE_I(ENABLE_I), .DISABLE_I(DISABLE_I),
  .SW_RESET_I(SW_RESET_I), .MASTER_SELECT_BIT_I(MASTER_SELECT_BIT_I), .FIXED_MODE_I(FIXED_MODE_I),
  .DMA_MODE_I(DMA_MODE_I), .CFG_WR_I(CFG_WR_I), .TDR_WR_I(TDR_WR_I), .RDR_RD_I(RDR_RD_I),
  .CFG_SEL_I(CFG_SEL_I), .CFG_I(CFG_I), .ENABLED_O(ENABLED_O), .TX_READY_O(TX_READY_O),
  .TRANSMIT_EMPTY_FLAG_O(TRANSMIT_EMPTY_FLAG_O), .RX_READY_O(RX_READY_O),
  .DMA_HALFWORD_O(DMA_HALFWORD_O), .SERIAL_CLOCK_PIN_OE_O(SERIAL_CLOCK_PIN_OE_O), .CS_N_O(CS_N_O));

// ---- testbench/serial_slave_model.sv ----
// Behavioural serial slave on the far side of the controller.
// Assumes clock polarity 0 with data changed on the falling edge.
`timescale 1ns/100ps
module serial_slave_model (
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic [3:0] cs_n_i,
  output logic miso_o,
  output logic [15:0] got_o,
  output int pulses_o
);
  logic sel_n, idle_v;
  logic [15:0] sh;
  assign sel_n = &cs_n_i;
  // Released line shows the inverse of its last bit
  assign miso_o = sel_n ? idle_v : sh[15];
  initial begin
    sh = 16'h5A3C;
    idle_v = 1'b0;
    got_o = '0;
    pulses_o = 0;
  end
  always @(negedge sel_n) sh <= 16'h5A3C;
  always @(posedge sel_n) idle_v <= ~sh[15];
  // Msb first out, captured on rising clock
  always @(negedge sclk_i) if (!sel_n) sh <= {sh[14:0], 1'b0};
  always @(posedge sclk_i) begin
    pulses_o <= pulses_o + 1;
    if (!sel_n) got_o <= {got_o[14:0], mosi_i};
  end
endmodule // serial_slave_model

// ---- testbench/serial_ctrl_tb.sv ----
// Self-checking bench for the serial controller.
// Assumes the checker is bound and the slave model sits on the pins.
`timescale 1ns/100ps
module serial_ctrl_tb import serial_ctrl_pkg::*; ;
  logic clk = 0, rst_n = 0, ena = 0, dis = 0, swr = 0, mst = 0, fix = 0, dma = 0;
  logic cfg_wr = 0, tdr_wr = 0, rd = 0;
  logic [1:0] cfg_sel = 0, fcs = 0;
  cs_cfg_s cfg = '0;
  logic [31:0] tdr = 0;
  logic en_o, rdy_o, emp_o, rxr_o, half_o, sck_o, sck_oe_o, mosi_o, miso;
  logic [15:0] rxd_o, got;
  logic [3:0] cs_n;
  int pulses, p0, err_total = 0, checks_done = 0;
  initial forever #50 clk = ~clk;
  serial_ctrl serial_ctrl_inst (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .ENABLE_I(ena), .DISABLE_I(dis), .SW_RESET_I(swr),
    .MASTER_SELECT_BIT_I(mst), .FIXED_MODE_I(fix), .DMA_MODE_I(dma),
    .CFG_WR_I(cfg_wr), .CFG_SEL_I(cfg_sel), .CFG_I(cfg),
    .TDR_WR_I(tdr_wr), .TDR_I(tdr), .FIXED_CS_I(fcs), .RDR_RD_I(rd),
    .ENABLED_O(en_o), .TX_READY_O(rdy_o), .TRANSMIT_EMPTY_FLAG_O(emp_o), .RX_READY_O(rxr_o),
    .RX_DATA_O(rxd_o), .DMA_HALFWORD_O(half_o), .SERIAL_CLOCK_PIN_O(sck_o),
    .SERIAL_CLOCK_PIN_OE_O(sck_oe_o), .SERIAL_CLOCK_PIN_I(1'b0), .MOSI_O(mosi_o),
    .MISO_I(miso), .CS_N_O(cs_n), .SLAVE_SEL_N_I(1'b1));
  serial_slave_model serial_slave_model_inst (.sclk_i(sck_o), .mosi_i(mosi_o),
    .cs_n_i(cs_n), .miso_o(miso), .got_o(got), .pulses_o(pulses));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tmo();
    err_total++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    conclude();
  endtask
  // Configuration write for one select
  task automatic setc(input logic [1:0] s, input logic [7:0] d, input logic [4:0] b, input logic h,
                      input logic p = 1'b0, input logic n = 1'b1);
    @(posedge clk);
    cfg_wr <= 1;
    cfg_sel <= s;
    cfg <= '{d, b, p, n, h};
    @(posedge clk);
    cfg_wr <= 0;
  endtask
  // Word write once ready is seen
  task automatic send(input logic [31:0] w);
    int i;
    for (i = 0; i < 2000 && rdy_o !== 1'b1; i++) @(posedge clk);
    if (i == 2000) tmo();
    tdr_wr <= 1;
    tdr <= w;
    @(posedge clk);
    tdr_wr <= 0;
  endtask
  // Whole word: send, read back, wait for empty
  task automatic xfer(input logic [31:0] w);
    int i;
    send(w);
    for (i = 0; i < 2000 && rxr_o !== 1'b1; i++) @(posedge clk);
    if (i == 2000) tmo();
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    for (i = 0; i < 2000 && emp_o !== 1'b1; i++) @(posedge clk);
    if (i == 2000) tmo();
    cyc(6);
  endtask
  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    cyc(16);
    rst_n <= 1;
    cyc(1);
    chk({rdy_o, emp_o, en_o, cs_n}, 7'h6F);
    mst <= 1;
    setc(0, 8'h04, 5'h08, 0);
    ena <= 1;
    cyc(1);
    ena <= 0;
    chk(pulses, 1);
    p0 = pulses;
    xfer(32'h0000_00C3);
    chk(pulses - p0, 8);
    chk(got[7:0], 8'hC3);
    chk(rxd_o[7:0], 8'h5A);
    $display("test basic done");
    for (int b = 8; b <= 16; b++) begin
      setc(0, 8'h01, b[4:0], 0);
      p0 = pulses;
      xfer(32'h0000_A5A5);
      chk(pulses - p0, b + b % 2);
    end
    $display("test lengths done");
    fix <= 1;
    dma <= 1;
    fcs <= 2'h1;
    setc(1, 8'h02, 5'h08, 0);
    setc(0, 8'h02, 5'h0A, 0);
    cyc(1);
    chk(half_o, 1);
    setc(0, 8'h02, 5'h08, 0);
    cyc(1);
    chk(half_o, 0);
    $display("test size done");
    setc(1, 8'h02, 5'h08, 1);
    xfer(32'h0000_0011);
    chk(cs_n, 4'hD);
    xfer(32'h0100_0022);
    chk(cs_n, 4'hF);
    $display("test final bit done");
    fix <= 0;
    dma <= 0;
    setc(1, 8'h02, 5'h08, 0, 1, 0);
    setc(0, 8'h01, 5'h08, 0, 1, 0);
    cyc(2);
    p0 = pulses;
    xfer(32'h0001_0055);
    chk(pulses - p0, 8);
    p0 = pulses;
    xfer(32'h0000_0066);
    chk(pulses - p0, 9);
    setc(1, 8'h01, 5'h08, 0, 1, 0);
    p0 = pulses;
    xfer(32'h0001_0077);
    xfer(32'h0000_0088);
    chk(pulses - p0, 16);
    $display("test select switch done");
    setc(0, 8'h01, 5'h08, 1);
    xfer(32'h0000_0033);
    send(32'h0000_0044);
    cyc(40);
    chk(rdy_o, 0);
    swr <= 1;
    cyc(1);
    swr <= 0;
    $display("test stuck ready done");
    mst <= 0;
    cyc(2);
    ena <= 1;
    cyc(1);
    ena <= 0;
    cyc(1);
    dis <= 1;
    cyc(1);
    dis <= 0;
    cyc(2);
    chk(en_o, 1);
    rd <= 1;
    cyc(1);
    rd <= 0;
    swr <= 1;
    cyc(1);
    swr <= 0;
    cyc(2);
    chk(en_o, 0);
    $display("test slave stop done");
    conclude();
  end
endmodule // serial_ctrl_tb
